/* File: hw/pid_frequency_regulator.sv */
// closed-loop process regulator with apb settings, loss detect and sleep
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module pid_frequency_regulator #(
  parameter int unsigned TICK_CYCLES = pid_regulator_pkg::TICK_CYCLES // control tick length
) (
  input  wire logic        clk_sys,       // 100 mhz system clock
  input  wire logic        srst,          // synchronous reset, active high
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic [12:0] feedback_in,   // feedback, q13 of full scale
  input  wire logic [15:0] freq_cmd_in,   // ordinary command, 0.01 hz
  input  wire logic        run_in,        // drive run request
  output logic      [15:0] freq_out,      // output frequency, 0.01 hz
  output logic             drive_stop,    // stop request to the ramp
  output logic             feedback_loss_indication, // loss shown
  output logic             sleep_active   // sleep mode
);
  localparam int FS = pid_regulator_pkg::FULL_SCALE;
  // settings
  logic [3:0]  action_q;
  logic [12:0] setpoint_q;
  logic [9:0]  fb_gain_q, kp_q, ti_q, td_q;
  logic [8:0]  offset_q;
  logic [4:0]  lag_q;
  logic [1:0]  loss_mode_q;
  logic [6:0]  loss_level_q, int_limit_q;
  logic [7:0]  loss_delay_q, sleep_delay_q, wake_delay_q;
  logic [4:0]  int_reset_q;
  logic [12:0] int_margin_q;
  logic [15:0] sleep_freq_q, wake_freq_q;
  logic [9:0]  fb_max_q, fb_min_q;
  // feedback pin synchroniser
  logic [12:0] fb_meta_q, fb_sync_q;
  always_ff @(posedge clk_sys)
  begin
    fb_meta_q <= feedback_in;
    fb_sync_q <= fb_meta_q;
  end
  // apb slave: zero wait, unmapped addresses read zero with pslverr
  logic        acc;
  logic        hit;
  logic [31:0] rd;
  logic [15:0] freq_q;
  logic        settled_stop_q, loss_q, sleep_q;
  logic [9:0]  disp_q;
  assign acc = psel & penable;
  always_comb
  begin
    hit = 1'b1;
    rd  = 32'h0;
    if (paddr == pid_regulator_pkg::ADDR_ACTION) rd = {28'h0, action_q};
    else if (paddr == pid_regulator_pkg::ADDR_SETPOINT) rd = {19'h0, setpoint_q};
    else if (paddr == pid_regulator_pkg::ADDR_FB_GAIN) rd = {22'h0, fb_gain_q};
    else if (paddr == pid_regulator_pkg::ADDR_KP) rd = {22'h0, kp_q};
    else if (paddr == pid_regulator_pkg::ADDR_TI) rd = {22'h0, ti_q};
    else if (paddr == pid_regulator_pkg::ADDR_TD) rd = {22'h0, td_q};
    else if (paddr == pid_regulator_pkg::ADDR_OFFSET) rd = {23'h0, offset_q};
    else if (paddr == pid_regulator_pkg::ADDR_LAG) rd = {27'h0, lag_q};
    else if (paddr == pid_regulator_pkg::ADDR_LOSS_MODE) rd = {30'h0, loss_mode_q};
    else if (paddr == pid_regulator_pkg::ADDR_LOSS_LEVEL) rd = {25'h0, loss_level_q};
    else if (paddr == pid_regulator_pkg::ADDR_LOSS_DELAY) rd = {24'h0, loss_delay_q};
    else if (paddr == pid_regulator_pkg::ADDR_INT_LIMIT) rd = {25'h0, int_limit_q};
    else if (paddr == pid_regulator_pkg::ADDR_INT_RESET) rd = {27'h0, int_reset_q};
    else if (paddr == pid_regulator_pkg::ADDR_INT_MARGIN) rd = {19'h0, int_margin_q};
    else if (paddr == pid_regulator_pkg::ADDR_SLEEP_FREQ) rd = {16'h0, sleep_freq_q};
    else if (paddr == pid_regulator_pkg::ADDR_SLEEP_DELAY) rd = {24'h0, sleep_delay_q};
    else if (paddr == pid_regulator_pkg::ADDR_WAKE_FREQ) rd = {16'h0, wake_freq_q};
    else if (paddr == pid_regulator_pkg::ADDR_WAKE_DELAY) rd = {24'h0, wake_delay_q};
    else if (paddr == pid_regulator_pkg::ADDR_FB_MAX) rd = {22'h0, fb_max_q};
    else if (paddr == pid_regulator_pkg::ADDR_FB_MIN) rd = {22'h0, fb_min_q};
    else if (paddr == pid_regulator_pkg::ADDR_STATUS)
      rd = {29'h0, settled_stop_q, sleep_q, loss_q};
    else if (paddr == pid_regulator_pkg::ADDR_OUT_FREQ) rd = {16'h0, freq_q};
    else if (paddr == pid_regulator_pkg::ADDR_FB_DISPLAY) rd = {22'h0, disp_q};
    else hit = 1'b0;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd : 32'h0;
    end
  end
  // settings writes; values above range saturate to the documented ceiling
  logic wr;
  assign wr = acc & pready & pwrite;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      action_q <= 4'h0;      setpoint_q <= 13'h0;    fb_gain_q <= 10'h064;
      kp_q <= 10'h00a;       ti_q <= 10'h00a;        td_q <= 10'h0;
      offset_q <= 9'h0;      lag_q <= 5'h0;          loss_mode_q <= 2'h0;
      loss_level_q <= 7'h0;  loss_delay_q <= 8'h0;   int_limit_q <= 7'h64;
      int_reset_q <= 5'h0;   int_margin_q <= 13'h0;  sleep_freq_q <= 16'h0;
      sleep_delay_q <= 8'h0; wake_freq_q <= 16'h0;   wake_delay_q <= 8'h0;
      fb_max_q <= 10'h3e7;   fb_min_q <= 10'h0;
    end
    else if (wr)
    begin
      if (paddr == pid_regulator_pkg::ADDR_ACTION)
        action_q <= (pwdata[3:0] > pid_regulator_pkg::ACT_MAX) ? 4'h8 : pwdata[3:0];
      else if (paddr == pid_regulator_pkg::ADDR_SETPOINT) setpoint_q <= pwdata[12:0];
      else if (paddr == pid_regulator_pkg::ADDR_FB_GAIN)
        fb_gain_q <= (pwdata[9:0] > 10'd1000) ? 10'd1000 : pwdata[9:0];
      else if (paddr == pid_regulator_pkg::ADDR_KP)
        kp_q <= (pwdata[9:0] > 10'd100) ? 10'd100 : pwdata[9:0];
      else if (paddr == pid_regulator_pkg::ADDR_TI)
        ti_q <= (pwdata[9:0] > 10'd1000) ? 10'd1000 : pwdata[9:0];
      else if (paddr == pid_regulator_pkg::ADDR_TD)
        td_q <= (pwdata[9:0] > 10'd1000) ? 10'd1000 : pwdata[9:0];
      else if (paddr == pid_regulator_pkg::ADDR_OFFSET)
        offset_q <= {pwdata[8], (pwdata[7:0] > 8'd109) ? 8'd109 : pwdata[7:0]};
      else if (paddr == pid_regulator_pkg::ADDR_LAG)
        lag_q <= (pwdata[4:0] > 5'd25) ? 5'd25 : pwdata[4:0];
      else if (paddr == pid_regulator_pkg::ADDR_LOSS_MODE)
        loss_mode_q <= (pwdata[1:0] == 2'h3) ? 2'h2 : pwdata[1:0];
      else if (paddr == pid_regulator_pkg::ADDR_LOSS_LEVEL)
        loss_level_q <= (pwdata[6:0] > 7'd100) ? 7'd100 : pwdata[6:0];
      else if (paddr == pid_regulator_pkg::ADDR_LOSS_DELAY) loss_delay_q <= pwdata[7:0];
      else if (paddr == pid_regulator_pkg::ADDR_INT_LIMIT)
        int_limit_q <= (pwdata[6:0] > 7'd109) ? 7'd109 : pwdata[6:0];
      else if (paddr == pid_regulator_pkg::ADDR_INT_RESET)
        int_reset_q <= (pwdata[4:0] > 5'd30) ? 5'd30 : pwdata[4:0];
      else if (paddr == pid_regulator_pkg::ADDR_INT_MARGIN) int_margin_q <= pwdata[12:0];
      else if (paddr == pid_regulator_pkg::ADDR_SLEEP_FREQ)
        sleep_freq_q <= (pwdata[15:0] > 16'd59900) ? 16'd59900 : pwdata[15:0];
      else if (paddr == pid_regulator_pkg::ADDR_SLEEP_DELAY) sleep_delay_q <= pwdata[7:0];
      else if (paddr == pid_regulator_pkg::ADDR_WAKE_FREQ)
        wake_freq_q <= (pwdata[15:0] > 16'd59900) ? 16'd59900 : pwdata[15:0];
      else if (paddr == pid_regulator_pkg::ADDR_WAKE_DELAY) wake_delay_q <= pwdata[7:0];
      else if (paddr == pid_regulator_pkg::ADDR_FB_MAX)
        fb_max_q <= (pwdata[9:0] > 10'd999) ? 10'd999 : pwdata[9:0];
      else if (paddr == pid_regulator_pkg::ADDR_FB_MIN)
        fb_min_q <= (pwdata[9:0] > 10'd999) ? 10'd999 : pwdata[9:0];
    end
  end
  // control tick divider: the loop runs once per tick, slow enough for shared math
  logic [31:0] div_q;
  logic        tick_q;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      div_q  <= 32'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == TICK_CYCLES - 1);
      div_q  <= (div_q == TICK_CYCLES - 1) ? 32'h0 : div_q + 32'h1;
    end
  end
  // deviation and terms, all in 1/8192 of full scale, signed
  logic signed [31:0] fb_scaled, dev, dsrc, pterm, dterm, integ_d, lim, raw, lagged_d;
  logic signed [31:0] integ_q, prev_q, lag_acc_q;
  logic               enabled, reverse, adding;
  assign enabled = (action_q != pid_regulator_pkg::ACT_OFF);
  assign reverse = (action_q >= pid_regulator_pkg::ACT_REV_MIN) &&
                   (action_q < pid_regulator_pkg::ACT_ADD_MIN) ||
                   (action_q >= 4'd7);
  assign adding  = (action_q >= pid_regulator_pkg::ACT_ADD_MIN);
  always_comb
  begin
    fb_scaled = (32'(fb_sync_q) * 32'(fb_gain_q)) / 100;
    dev   = 32'(setpoint_q) - fb_scaled;
    if (reverse)
      dev = -dev;
    dsrc  = action_q[0] ? dev : (reverse ? fb_scaled : -fb_scaled);
    // gains are made signed: an unsigned operand would divide negative terms as huge values
    pterm = (dev * $signed(32'(kp_q))) / 10;
    dterm = ((dsrc - prev_q) * $signed(32'(td_q)) *
             $signed(32'(pid_regulator_pkg::TICKS_PER_S))) / 100;
    lim   = (32'(int_limit_q) * FS) / 100;
    integ_d = integ_q;
    if (ti_q != 10'h0)
      integ_d = integ_q + (pterm * 10) /
                $signed(32'(ti_q) * 32'(pid_regulator_pkg::TICKS_PER_S));
    if (integ_d > lim)
      integ_d = lim;
    else if (integ_d < -lim)
      integ_d = -lim;
    raw = pterm + integ_q + dterm;
    if (offset_q[8])
      raw = raw - (32'(offset_q[7:0]) * FS) / 100;
    else
      raw = raw + (32'(offset_q[7:0]) * FS) / 100;
    lagged_d = raw;
    if (lag_q != 5'h0)
      lagged_d = lag_acc_q + (raw - lag_acc_q) / $signed(32'(lag_q) + 32'h1);
  end
  // settle timer for integrator clear
  logic [31:0] err_abs;
  logic [9:0]  settle_cnt_q;
  logic        clear_int;
  assign err_abs   = (32'(setpoint_q) > fb_scaled) ? 32'(setpoint_q) - fb_scaled
                                                   : fb_scaled - 32'(setpoint_q);
  assign clear_int = (int_reset_q != 5'h0) && (err_abs <= 32'(int_margin_q)) &&
                     (settle_cnt_q >= 10'(int_reset_q * pid_regulator_pkg::TICKS_PER_S));
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      integ_q <= 32'sh0; prev_q <= 32'sh0; lag_acc_q <= 32'sh0;
      settle_cnt_q <= 10'h0; settled_stop_q <= 1'b0;
    end
    else if (tick_q)
    begin
      prev_q <= dsrc;
      if (!enabled || !run_in)
      begin
        integ_q <= 32'sh0; lag_acc_q <= 32'sh0; settled_stop_q <= 1'b0; settle_cnt_q <= 10'h0;
      end
      else
      begin
        lag_acc_q <= lagged_d;
        if (settled_stop_q)
        begin
          integ_q <= 32'sh0;
          if (err_abs > 32'(int_margin_q))
            settled_stop_q <= 1'b0;
        end
        else if (clear_int)
        begin
          integ_q <= 32'sh0;
          settled_stop_q <= 1'b1;
          settle_cnt_q <= 10'h0;
        end
        else
        begin
          integ_q <= integ_d;
          settle_cnt_q <= (err_abs <= 32'(int_margin_q)) ? settle_cnt_q + 10'h1 : 10'h0;
        end
      end
    end
  end
  // regulator output to frequency, adding the command in modes 5..8
  logic signed [31:0] pid_hz, tot_hz;
  always_comb
  begin
    pid_hz = (lag_acc_q > 0) ? (lag_acc_q * 32'(pid_regulator_pkg::FREQ_MAX)) / FS : 32'sh0;
    tot_hz = adding ? pid_hz + 32'(freq_cmd_in) : pid_hz;
    if (tot_hz > 32'(pid_regulator_pkg::FREQ_MAX))
      tot_hz = 32'(pid_regulator_pkg::FREQ_MAX);
  end
  // feedback loss: error above level for the delay
  logic [8:0] loss_cnt_q;
  logic       loss_cond;
  // signed compare: feedback above the set point must never look like a loss
  assign loss_cond = $signed(32'(setpoint_q) - fb_scaled) >
                     $signed((32'(loss_level_q) * FS) / 100);
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      loss_cnt_q <= 9'h0;
      loss_q     <= 1'b0;
    end
    else if (loss_mode_q == pid_regulator_pkg::LOSS_OFF || !enabled)
    begin
      loss_cnt_q <= 9'h0;
      loss_q     <= 1'b0;
    end
    else if (tick_q)
    begin
      if (!loss_cond)
        loss_cnt_q <= 9'h0;
      else if (loss_cnt_q >= {1'b0, loss_delay_q})
        loss_q <= 1'b1;
      else
        loss_cnt_q <= loss_cnt_q + 9'h1;
    end
  end
  // sleep and wake with their own delays
  logic [8:0] sw_cnt_q;
  always_ff @(posedge clk_sys)
  begin
    if (srst || !enabled)
    begin
      sw_cnt_q <= 9'h0;
      sleep_q  <= 1'b0;
    end
    else if (tick_q)
    begin
      if (!sleep_q)
      begin
        if (pid_hz >= 32'(sleep_freq_q))
          sw_cnt_q <= 9'h0;
        else if (sw_cnt_q > {1'b0, sleep_delay_q})
        begin
          sleep_q  <= 1'b1;
          sw_cnt_q <= 9'h0;
        end
        else
          sw_cnt_q <= sw_cnt_q + 9'h1;
      end
      else if (pid_hz <= 32'(wake_freq_q))
        sw_cnt_q <= 9'h0;
      else if (sw_cnt_q >= {1'b0, wake_delay_q})
      begin
        sleep_q  <= 1'b0;
        sw_cnt_q <= 9'h0;
      end
      else
        sw_cnt_q <= sw_cnt_q + 9'h1;
    end
  end
  // outputs; sleep, settled stop and stop-on-loss force zero with a stop request
  logic stop_now;
  assign stop_now = sleep_q || settled_stop_q ||
                    (loss_q && loss_mode_q == pid_regulator_pkg::LOSS_STOP);
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      freq_q <= 16'h0; drive_stop <= 1'b0; freq_out <= 16'h0;
      feedback_loss_indication <= 1'b0; sleep_active <= 1'b0;
    end
    else
    begin
      freq_q     <= !enabled ? freq_cmd_in : (stop_now ? 16'h0 : tot_hz[15:0]);
      freq_out   <= freq_q;
      drive_stop <= enabled && stop_now;
      feedback_loss_indication <= loss_q;
      sleep_active <= sleep_q;
    end
  end
  // display scaling only; the loop never reads it
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      disp_q <= 10'h0;
    else
      disp_q <= 10'(32'(fb_min_q) +
                 ((32'(fb_max_q) - 32'(fb_min_q)) * 32'(fb_sync_q)) / (FS - 1));
  end
endmodule : pid_frequency_regulator

/* File: hw/pid_regulator_pkg.sv */
// constants shared by the process regulator and its register file
package pid_regulator_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_ACTION      = 8'h00; // action setting 0..8
  localparam logic [7:0] ADDR_SETPOINT    = 8'h04; // set point, q13 unsigned
  localparam logic [7:0] ADDR_FB_GAIN     = 8'h08; // feedback gain x100
  localparam logic [7:0] ADDR_KP          = 8'h0c; // proportional gain x10
  localparam logic [7:0] ADDR_TI          = 8'h10; // integral time x0.1 s
  localparam logic [7:0] ADDR_TD          = 8'h14; // derivative time x0.01 s
  localparam logic [7:0] ADDR_OFFSET      = 8'h18; // [7:0] percent, [8] negative
  localparam logic [7:0] ADDR_LAG         = 8'h1c; // lag time x0.1 s
  localparam logic [7:0] ADDR_LOSS_MODE   = 8'h20; // loss mode 0..2
  localparam logic [7:0] ADDR_LOSS_LEVEL  = 8'h24; // loss level 0..100
  localparam logic [7:0] ADDR_LOSS_DELAY  = 8'h28; // loss delay x0.1 s
  localparam logic [7:0] ADDR_INT_LIMIT   = 8'h2c; // integral limit percent
  localparam logic [7:0] ADDR_INT_RESET   = 8'h30; // integral reset seconds
  localparam logic [7:0] ADDR_INT_MARGIN  = 8'h34; // restart margin, 1/8192 units
  localparam logic [7:0] ADDR_SLEEP_FREQ  = 8'h38; // sleep freq x0.01 Hz
  localparam logic [7:0] ADDR_SLEEP_DELAY = 8'h3c; // sleep delay x0.1 s
  localparam logic [7:0] ADDR_WAKE_FREQ   = 8'h40; // wake freq x0.01 Hz
  localparam logic [7:0] ADDR_WAKE_DELAY  = 8'h44; // wake delay x0.1 s
  localparam logic [7:0] ADDR_FB_MAX      = 8'h48; // display max 0..999
  localparam logic [7:0] ADDR_FB_MIN      = 8'h4c; // display min 0..999
  localparam logic [7:0] ADDR_STATUS      = 8'h50; // read only status
  localparam logic [7:0] ADDR_OUT_FREQ    = 8'h54; // read only output frequency
  localparam logic [7:0] ADDR_FB_DISPLAY  = 8'h58; // read only display value
  // limits and scales
  localparam int unsigned FULL_SCALE   = 8192;    // one unit = 1/8192 of full
  localparam int unsigned FREQ_MAX     = 59900;   // 599.00 Hz in 0.01 Hz
  localparam int unsigned PCT_MAX      = 109;     // offset and limit ceiling
  localparam int unsigned TICK_MS      = 100;     // control tick period in ms
  localparam int unsigned CLK_MHZ      = 100;     // system clock
  localparam int unsigned TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ; // 10,000,000
  localparam int unsigned TICKS_PER_S  = 1000 / TICK_MS;
  // action settings
  localparam logic [3:0] ACT_OFF      = 4'h0;
  localparam logic [3:0] ACT_REV_MIN  = 4'h3;
  localparam logic [3:0] ACT_ADD_MIN  = 4'h5;
  localparam logic [3:0] ACT_MAX      = 4'h8;
  // loss modes
  localparam logic [1:0] LOSS_OFF  = 2'h0;
  localparam logic [1:0] LOSS_RUN  = 2'h1;
  localparam logic [1:0] LOSS_STOP = 2'h2;
endpackage : pid_regulator_pkg

/* File: tb/pid_regulator_checker_assertions.sv */
// port checker for the process regulator, bound onto the design
`timescale 1ns/1ps
module pid_regulator_checker (
  input wire logic        clk_sys,                  // system clock
  input wire logic        srst,                     // synchronous reset
  input wire logic        psel,                     // apb select
  input wire logic        penable,                  // apb enable
  input wire logic        pwrite,                   // apb direction
  input wire logic [7:0]  paddr,                    // apb address
  input wire logic [31:0] pwdata,                   // apb write data
  input wire logic [31:0] prdata,                   // apb read data
  input wire logic        pready,                   // apb ready
  input wire logic        pslverr,                  // apb error
  input wire logic [15:0] freq_cmd_in,              // ordinary command
  input wire logic [15:0] freq_out,                 // output frequency
  input wire logic        drive_stop,               // stop request
  input wire logic        feedback_loss_indication, // loss shown
  input wire logic        sleep_active              // sleep mode
);
  logic [3:0] act_q;
  logic [1:0] mode_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // shadow copies of the settings, saturated like the register file
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      act_q  <= 4'h0;
      mode_q <= 2'h0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == pid_regulator_pkg::ADDR_ACTION)
        act_q <= (pwdata[3:0] > 4'h8) ? 4'h8 : pwdata[3:0];
      if (paddr == pid_regulator_pkg::ADDR_LOSS_MODE)
        mode_q <= (pwdata[1:0] == 2'h3) ? 2'h2 : pwdata[1:0];
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence status_rd_s;
    psel && !penable && !pwrite && paddr == pid_regulator_pkg::ADDR_STATUS;
  endsequence
  AST_READY_AFTER_SETUP: assert property (setup_s |=> psel && penable && pready)
    else $error("ready missing after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_UNMAPPED_ERR: assert property (setup_s ##0 paddr > 8'h58 |=> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_READ_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  AST_OFF_PASSTHRU: assert property ((!srst && act_q == 4'h0)[*3] |->
    freq_out == $past(freq_cmd_in, 2)) else $error("disabled loop not passing command");
  AST_LOSS_OFF: assert property ((!srst && mode_q == 2'h0)[*3] |->
    !feedback_loss_indication) else $error("loss shown while detection off");
  AST_LOSS_STOP: assert property (mode_q == 2'h2 && act_q != 4'h0 &&
    feedback_loss_indication |-> ##[0:2] drive_stop) else $error("loss did not stop drive");
  AST_STATUS_BITS: assert property (status_rd_s ##1 $stable({sleep_active,
    feedback_loss_indication}) |-> prdata[1:0] == {sleep_active, feedback_loss_indication})
    else $error("status bits disagree with outputs");
endmodule : pid_regulator_checker
bind pid_frequency_regulator pid_regulator_checker u_chk (.clk_sys, .srst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .freq_cmd_in, .freq_out,
  .drive_stop, .feedback_loss_indication, .sleep_active);

/* File: tb/pid_feedback_model.sv */
// feedback sensor model: settles on a target promptly or creeps slowly
`timescale 1ns/1ps
module pid_feedback_model (
  input  wire logic        clk_sys,    // system clock
  input  wire logic        srst,       // synchronous reset
  input  wire logic [12:0] target,     // level the sensor settles to
  input  wire logic        slow,       // creep one code per cycle
  output logic      [12:0] feedback_in // sensor value to the regulator
);
  // a creeping sensor keeps the derivative path busy instead of one step
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      feedback_in <= 13'h0000;
    else if (!slow)
      feedback_in <= target;
    else if (feedback_in < target)
      feedback_in <= feedback_in + 13'h0001;
    else if (feedback_in > target)
      feedback_in <= feedback_in - 13'h0001;
  end
endmodule : pid_feedback_model

/* File: tb/pid_frequency_regulator_test.sv */
// self-checking bench for the process regulator
`timescale 1ns/1ps
module pid_frequency_regulator_test;
  localparam int unsigned TICK = 20; // short control tick keeps the run brief
  logic        clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        run_in = 1'b0, fb_slow = 1'b0, pready, pslverr, er, drive_stop;
  logic        feedback_loss_indication, sleep_active;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [12:0] fb_target = 13'h0000, feedback_in;
  logic [15:0] freq_cmd_in = 16'h0000, freq_out;
  integer      seed = 32'h23ff425e;
  int          num_errors = 0, total_checks = 0, cyc = 0, a;
  pid_frequency_regulator #(.TICK_CYCLES(TICK)) u_dut (.clk_sys, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .feedback_in, .freq_cmd_in,
    .run_in, .freq_out, .drive_stop, .feedback_loss_indication, .sleep_active);
  pid_feedback_model u_fb (.clk_sys, .srst, .target(fb_target), .slow(fb_slow), .feedback_in);
  // clock, and a hang guard well past the longest scenario
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32
  task automatic chk1(input string nm, input logic e, input logic g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk1("ready", 1'b1, n < 20);
  endtask : apb
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk32($sformatf("reg %h", ad), e, rd);
  endtask : rdc
  // forward actions 1,2,5,6 push the output up on a positive deviation
  function automatic logic exp_up(input int act);
    return ((act - 1) % 4) < 2;
  endfunction : exp_up
  // restart the loop with fresh settings, settle, then judge the direction
  task automatic run_case(input int act, input int sp, input int g, input int fb, input logic up);
    logic [15:0] cmd;
    cmd = 16'($unsigned($random(seed)) % 30000);
    run_in <= 1'b0;
    apb(1'b1, pid_regulator_pkg::ADDR_ACTION, act);
    apb(1'b1, pid_regulator_pkg::ADDR_SETPOINT, sp);
    apb(1'b1, pid_regulator_pkg::ADDR_FB_GAIN, g);
    fb_target <= 13'(fb);
    fb_slow <= (g == 0); // a zero gain must ignore even a moving sensor
    freq_cmd_in <= cmd;
    run_in <= 1'b1;
    repeat (15 * TICK) @(posedge clk_sys);
    chk1("direction", up, freq_out > ((act > 4) ? cmd : 16'h0000));
  endtask : run_case
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rdc(pid_regulator_pkg::ADDR_FB_GAIN, 32'd100);
    rdc(pid_regulator_pkg::ADDR_KP, 32'd10);
    rdc(pid_regulator_pkg::ADDR_TI, 32'd10);
    rdc(pid_regulator_pkg::ADDR_INT_LIMIT, 32'd100);
    rdc(pid_regulator_pkg::ADDR_FB_MAX, 32'd999);
    fb_target <= 13'h1fff;
    apb(1'b1, pid_regulator_pkg::ADDR_FB_MIN, 32'd50);
    apb(1'b1, pid_regulator_pkg::ADDR_FB_MAX, 32'd100);
    rdc(pid_regulator_pkg::ADDR_FB_DISPLAY, 32'd100);
    apb(1'b1, pid_regulator_pkg::ADDR_OFFSET, 32'h1ff);
    rdc(pid_regulator_pkg::ADDR_OFFSET, 32'h16d);
    apb(1'b1, pid_regulator_pkg::ADDR_OFFSET, 32'h0);
    apb(1'b0, 8'hf0, 32'h0);
    chk1("unmapped error", 1'b1, er);
    chk32("unmapped data", 32'h0, rd);
    apb(1'b1, pid_regulator_pkg::ADDR_ACTION, 32'hf);
    rdc(pid_regulator_pkg::ADDR_ACTION, 32'h8);
    apb(1'b1, pid_regulator_pkg::ADDR_LOSS_MODE, 32'h3);
    rdc(pid_regulator_pkg::ADDR_LOSS_MODE, 32'h2);
    apb(1'b1, pid_regulator_pkg::ADDR_LOSS_MODE, 32'h0);
    for (a = 1; a <= 8; a++)
      run_case(a, 8191, 100, 0, exp_up(a));
    run_case(1, 4096, 0, 8191, 1'b1);
    run_case(1, 4096, 100, 8191, 1'b0);
    apb(1'b1, pid_regulator_pkg::ADDR_ACTION, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk32("passthru", {16'h0, freq_cmd_in}, {16'h0, freq_out});
    // loss: condition held off first so the delay count starts clean
    run_case(1, 8191, 100, 8191, 1'b0);
    apb(1'b1, pid_regulator_pkg::ADDR_LOSS_LEVEL, 32'd10);
    apb(1'b1, pid_regulator_pkg::ADDR_LOSS_DELAY, 32'd2);
    apb(1'b1, pid_regulator_pkg::ADDR_LOSS_MODE, 32'd1);
    fb_target <= 13'h0000;
    repeat (TICK) @(posedge clk_sys);
    chk1("loss early", 1'b0, feedback_loss_indication);
    repeat (4 * TICK) @(posedge clk_sys);
    chk1("loss", 1'b1, feedback_loss_indication);
    chk1("run on loss", 1'b0, drive_stop);
    rdc(pid_regulator_pkg::ADDR_STATUS, 32'h1);
    apb(1'b1, pid_regulator_pkg::ADDR_LOSS_MODE, 32'd2);
    repeat (TICK) @(posedge clk_sys);
    chk1("stop on loss", 1'b1, drive_stop);
    apb(1'b1, pid_regulator_pkg::ADDR_LOSS_MODE, 32'd0);
    // sleep under a reverse loop pinned at zero, then wake by turning forward
    run_case(3, 8191, 100, 0, 1'b0);
    apb(1'b1, pid_regulator_pkg::ADDR_SLEEP_FREQ, 32'd100);
    apb(1'b1, pid_regulator_pkg::ADDR_SLEEP_DELAY, 32'd1);
    apb(1'b1, pid_regulator_pkg::ADDR_WAKE_FREQ, 32'd50);
    repeat (6 * TICK) @(posedge clk_sys);
    chk1("sleep", 1'b1, sleep_active);
    apb(1'b1, pid_regulator_pkg::ADDR_ACTION, 32'd1);
    repeat (12 * TICK) @(posedge clk_sys);
    chk1("wake", 1'b0, sleep_active);
    rdc(pid_regulator_pkg::ADDR_FB_DISPLAY, 32'd50);
    final_report();
  end
endmodule : pid_frequency_regulator_test
